// file: src/tf_regs.vh
/*
  Command codes, field positions, reset values and timing figures for the
  temperature fault response block. Definitions only; included by name.
*/
`ifndef TF_REGS_VH
`define TF_REGS_VH
// command codes
`define TF_CMD_CLEAR   8'h03
`define TF_CMD_OT_FLT  8'h4F
`define TF_CMD_ACT     8'h50
`define TF_CMD_OT_WRN  8'h51
`define TF_CMD_UT_WRN  8'h52
`define TF_CMD_UT_FLT  8'h53
`define TF_CMD_STATUS  8'h7D
// action byte fields
`define TF_ACT_MODE    7:6
`define TF_ACT_RETRY   5:3
`define TF_ACT_DELAY   2:0
`define TF_MODE_RETRY  2'h2
`define TF_MODE_RESUME 2'h3
`define TF_RETRY_NONE  3'h0
`define TF_RETRY_LOOP  3'h7
// status bit positions
`define TF_ST_OTF      7
`define TF_ST_OTW      6
`define TF_ST_UTW      5
`define TF_ST_UTF      4
// reset values and device address
`define TF_ACT_RST     8'h80
`define TF_OTF_RST     16'h0064
`define TF_OTW_RST     16'h005A
`define TF_UTW_RST     16'hFFE2
`define TF_UTF_RST     16'hFFD8
`define TF_DEV_ADDR    7'h40
// timing: retry step in ms, clock in kHz
`define TF_RETRY_STEP_MS 35
`define TF_CLK_KHZ       10000
// one retry step in clock cycles: 35 ms at 10 MHz
`define TF_RETRY_STEP_CYC 19'h55730
`endif

// file: src/tf_smb_slave.v
/*
  Byte-level SMBus target: start/stop detection, address match, ack,
  write bytes out as events, read bytes fetched from tx_byte.
  Assumes scl/sda come from pins in another domain; clk is much faster.
*/
`timescale 1ns/100ps
`include "tf_regs.vh"
module tf_smb_slave (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out_q,
  output reg        sda_oe_q,
  // byte events
  output reg        ev_byte_q,
  output reg  [7:0] ev_data_q,
  output reg  [1:0] ev_idx_q,
  output reg  [1:0] rd_idx_q,
  input  wire [7:0] tx_byte
);
  localparam IDLE = 3'd0;
  localparam ADDR = 3'd1;
  localparam ACK  = 3'd2;
  localparam WDAT = 3'd3;
  localparam RDAT = 3'd4;
  localparam RACK = 3'd5;

  reg [1:0] scl_sy_q;
  reg [1:0] sda_sy_q;
  reg       scl_p_q;
  reg       sda_p_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] txs_q;
  reg [1:0] idx_q;
  reg       rw_q;
  reg       ack_ok_q;

  wire scl   = scl_sy_q[1];
  wire sda   = sda_sy_q[1];
  wire rise  = scl & ~scl_p_q;
  wire fall  = ~scl & scl_p_q;
  wire start = scl & scl_p_q & sda_p_q & ~sda;
  wire stop  = scl & scl_p_q & ~sda_p_q & sda;

  // two-flop synchronisers, then one delay stage for edges
  always @(posedge clk) begin
    if (rst) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_in};
      sda_sy_q <= {sda_sy_q[0], sda_in};
      scl_p_q  <= scl;
      sda_p_q  <= sda;
    end
  end

  // bit engine: sample on scl rise, drive on scl fall
  always @(posedge clk) begin
    if (rst) begin
      st_q      <= IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      txs_q     <= 8'h00;
      idx_q     <= 2'h0;
      rw_q      <= 1'b0;
      ack_ok_q  <= 1'b0;
      sda_out_q <= 1'b0;
      sda_oe_q  <= 1'b0;
      ev_byte_q <= 1'b0;
      ev_data_q <= 8'h00;
      ev_idx_q  <= 2'h0;
      rd_idx_q  <= 2'h0;
    end else begin
      ev_byte_q <= 1'b0;
      if (start) begin
        st_q     <= ADDR;
        bit_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop) begin
        st_q     <= IDLE;
        sda_oe_q <= 1'b0;
      end else if (rise) begin
        case (st_q)
          ADDR, WDAT: begin
            sh_q  <= {sh_q[6:0], sda};
            bit_q <= bit_q + 4'h1;
          end
          RDAT: bit_q <= bit_q + 4'h1;
          RACK: ack_ok_q <= ~sda;
          default: ;
        endcase
      end else if (fall) begin
        case (st_q)
          ADDR: if (bit_q == 4'h8) begin
            if (sh_q[7:1] == `TF_DEV_ADDR) begin
              sda_oe_q <= 1'b1;
              rw_q     <= sh_q[0];
              st_q     <= ACK;
              rd_idx_q <= 2'h0;
              if (!sh_q[0]) idx_q <= 2'h0;
            end else begin
              st_q <= IDLE;
            end
          end
          WDAT: if (bit_q == 4'h8) begin
            sda_oe_q  <= 1'b1;
            st_q      <= ACK;
            ev_byte_q <= 1'b1;
            ev_data_q <= sh_q;
            ev_idx_q  <= idx_q;
            if (idx_q != 2'h3) idx_q <= idx_q + 2'h1;
          end
          ACK: begin
            bit_q <= 4'h0;
            if (rw_q) begin
              txs_q    <= {tx_byte[6:0], 1'b0};
              sda_oe_q <= ~tx_byte[7];
              st_q     <= RDAT;
            end else begin
              sda_oe_q <= 1'b0;
              st_q     <= WDAT;
            end
          end
          RDAT: if (bit_q == 4'h8) begin
            sda_oe_q <= 1'b0;
            st_q     <= RACK;
            if (rd_idx_q != 2'h3) rd_idx_q <= rd_idx_q + 2'h1;
          end else begin
            sda_oe_q <= ~txs_q[7];
            txs_q    <= {txs_q[6:0], 1'b0};
          end
          RACK: if (ack_ok_q) begin
            bit_q    <= 4'h0;
            txs_q    <= {tx_byte[6:0], 1'b0};
            sda_oe_q <= ~tx_byte[7];
            st_q     <= RDAT;
          end else begin
            st_q <= IDLE; // nack ends the read
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// file: src/tf_fault_resp.v
/*
  Temperature fault response block: threshold and action commands over
  SMBus, sticky temperature status, alert line and output-enable control.
  Assumes temp_val is a signed word on clk in the same scale as the
  thresholds, and on_cmd is the output-on request from logic on clk.
*/
// How it works
// RULE1 - any over-temperature fault pulls alert low and latches its status bit
// RULE2 - mode 10 turns output off at once, then retries per retry count
// RULE3 - mode 11 turns output off, resumes once temperature is below warn limit
// RULE4 - three-bit retry count gives number of restart attempts after shutdown
// RULE5 - retry count zero: no restart, output stays off until faults cleared
// RULE6 - retry count seven: retry forever until commanded off or other shutdown
// RULE7 - retries spaced by (delay field plus one) times 35 ms
// RULE8 - action byte is a read/write byte command at code 0x50
// RULE9 - over-temperature warning word, read/write, at code 0x51
// RULE10 - under-temperature warning word, read/write, at code 0x52
// RULE11 - under-temperature fault word, read/write, at code 0x53
// RULE12 - over-temperature fault judged against read/write word at code 0x4F
// RULE13 - fault above over limit, under fault below under limit
// RULE14 - modes 00 and 01 keep output running but still flag the fault
`timescale 1ns/100ps
`include "tf_regs.vh"
module tf_fault_resp #(
  parameter [18:0] RETRY_STEP_CYC = `TF_RETRY_STEP_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // smbus pins
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  // measurement and control
  input  wire [15:0] temp_val,
  input  wire        on_cmd,
  // outputs
  output reg         out_en_q,
  output reg         alert_line_n_out_q,
  output reg         alert_line_n_oe_q
);
  localparam RUN    = 3'd0;
  localparam WAIT   = 3'd1;
  localparam RESUME = 3'd2;
  localparam HOLD   = 3'd3;
  localparam OFF    = 3'd4;
  localparam [18:0] STEP_LAST = RETRY_STEP_CYC - 19'h1;

  wire        ev_byte;
  wire [7:0]  ev_data;
  wire [1:0]  ev_idx;
  wire [1:0]  rd_idx;
  reg  [7:0]  tx_byte;

  reg  [7:0]  act_q;
  reg  [15:0] otf_q;
  reg  [15:0] otw_q;
  reg  [15:0] utw_q;
  reg  [15:0] utf_q;
  reg  [7:0]  cmd_q;
  reg  [7:0]  lo_q;
  reg  [7:0]  stat_q;
  reg  [7:0]  stat_d;
  reg  [2:0]  fs_q;
  reg  [2:0]  fs_d;
  reg  [2:0]  left_q;
  reg  [2:0]  left_d;
  reg  [2:0]  left_eff;
  reg         retrying_q;
  reg         retrying_d;
  reg  [2:0]  dly_q;
  reg  [18:0] div_q;
  reg  [2:0]  steps_q;

  tf_smb_slave u_smb (
    .clk       (clk),
    .rst       (rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out_q (sda_out),
    .sda_oe_q  (sda_oe),
    .ev_byte_q (ev_byte),
    .ev_data_q (ev_data),
    .ev_idx_q  (ev_idx),
    .rd_idx_q  (rd_idx),
    .tx_byte   (tx_byte)
  );

  // pick one byte of a word, low byte first
  function [7:0] pick;
    input [15:0] w;
    input [1:0]  i;
    begin
      pick = (i == 2'h0) ? w[7:0] : w[15:8];
    end
  endfunction

  // comparisons as signed raw words; no linear-format rescaling here
  wire ot_now  = $signed(temp_val) > $signed(otf_q); // RULE12 RULE13
  wire otw_now = $signed(temp_val) > $signed(otw_q);
  wire otw_low = $signed(temp_val) < $signed(otw_q);
  wire utw_now = $signed(temp_val) < $signed(utw_q);
  wire utf_now = $signed(temp_val) < $signed(utf_q); // RULE13

  // write decode from bus events
  wire wr_cmd   = ev_byte & (ev_idx == 2'h0);
  wire wr_b1    = ev_byte & (ev_idx == 2'h1);
  wire wr_b2    = ev_byte & (ev_idx == 2'h2);
  wire clr_all  = wr_cmd & (ev_data == `TF_CMD_CLEAR);
  wire clr_w1c  = wr_b1 & (cmd_q == `TF_CMD_STATUS);
  wire step_tk  = (fs_q == WAIT) & (div_q == STEP_LAST);
  wire dly_done = step_tk & (steps_q == dly_q);

  // read mux; unmapped commands answer all ones
  always @* begin
    case (cmd_q)
      `TF_CMD_ACT:    tx_byte = act_q; // RULE8
      `TF_CMD_OT_FLT: tx_byte = pick(otf_q, rd_idx); // RULE12
      `TF_CMD_OT_WRN: tx_byte = pick(otw_q, rd_idx); // RULE9
      `TF_CMD_UT_WRN: tx_byte = pick(utw_q, rd_idx); // RULE10
      `TF_CMD_UT_FLT: tx_byte = pick(utf_q, rd_idx); // RULE11
      `TF_CMD_STATUS: tx_byte = stat_q;
      default:        tx_byte = 8'hFF;
    endcase
  end

  // command byte, low byte holding and register writes
  always @(posedge clk) begin
    if (rst) begin
      cmd_q <= 8'h00;
      lo_q  <= 8'h00;
      act_q <= `TF_ACT_RST;
      otf_q <= `TF_OTF_RST;
      otw_q <= `TF_OTW_RST;
      utw_q <= `TF_UTW_RST;
      utf_q <= `TF_UTF_RST;
    end else begin
      if (wr_cmd) cmd_q <= ev_data;
      if (wr_b1) lo_q <= ev_data;
      if (wr_b1 && cmd_q == `TF_CMD_ACT) act_q <= ev_data; // RULE8
      if (wr_b2) begin
        case (cmd_q)
          `TF_CMD_OT_FLT: otf_q <= {ev_data, lo_q}; // RULE12
          `TF_CMD_OT_WRN: otw_q <= {ev_data, lo_q}; // RULE9
          `TF_CMD_UT_WRN: utw_q <= {ev_data, lo_q}; // RULE10
          `TF_CMD_UT_FLT: utf_q <= {ev_data, lo_q}; // RULE11
          default: ;
        endcase
      end
    end
  end

  // sticky status: a live condition beats a clear in the same cycle
  always @* begin
    stat_d = stat_q;
    if (clr_all) stat_d = 8'h00;
    if (clr_w1c) stat_d = stat_q & ~ev_data;
    stat_d[`TF_ST_OTF] = stat_d[`TF_ST_OTF] | ot_now; // RULE1
    stat_d[`TF_ST_OTW] = stat_d[`TF_ST_OTW] | otw_now;
    stat_d[`TF_ST_UTW] = stat_d[`TF_ST_UTW] | utw_now;
    stat_d[`TF_ST_UTF] = stat_d[`TF_ST_UTF] | utf_now;
  end

  // output state machine
  always @* begin
    fs_d       = fs_q;
    left_d     = left_q;
    retrying_d = retrying_q;
    left_eff   = retrying_q ? left_q : act_q[`TF_ACT_RETRY]; // RULE4
    case (fs_q)
      RUN: begin
        if (!on_cmd) begin
          fs_d = OFF;
        end else if (ot_now) begin
          case (act_q[`TF_ACT_MODE])
            `TF_MODE_RETRY: begin
              if (left_eff == `TF_RETRY_NONE) begin
                fs_d = HOLD; // RULE5
              end else begin
                fs_d       = WAIT; // RULE2
                retrying_d = 1'b1;
                // all ones never counts down
                if (act_q[`TF_ACT_RETRY] == `TF_RETRY_LOOP) left_d = left_eff; // RULE6
                else left_d = left_eff - 3'h1; // RULE4
              end
            end
            `TF_MODE_RESUME: fs_d = RESUME; // RULE3
            default: fs_d = RUN; // RULE14
          endcase
        end
      end
      WAIT: begin
        if (!on_cmd) fs_d = OFF; // RULE6
        else if (dly_done) fs_d = RUN; // RULE7
      end
      RESUME: begin
        if (!on_cmd) fs_d = OFF;
        else if (otw_low) fs_d = RUN; // RULE3
      end
      HOLD: begin
        if (!on_cmd) fs_d = OFF;
        else if (clr_all) fs_d = RUN; // RULE5
      end
      OFF: if (on_cmd) fs_d = RUN;
      default: fs_d = OFF;
    endcase
    if (fs_d == OFF || clr_all) retrying_d = 1'b0;
  end

  // state, retry timer and output flops
  always @(posedge clk) begin
    if (rst) begin
      fs_q               <= OFF;
      left_q             <= 3'h0;
      retrying_q         <= 1'b0;
      dly_q              <= 3'h0;
      div_q              <= 19'h0;
      steps_q            <= 3'h0;
      stat_q             <= 8'h00;
      out_en_q           <= 1'b0;
      alert_line_n_out_q <= 1'b0;
      alert_line_n_oe_q  <= 1'b0;
    end else begin
      fs_q       <= fs_d;
      left_q     <= left_d;
      retrying_q <= retrying_d;
      stat_q     <= stat_d;
      // delay latched on entry so a rewrite mid-wait cannot stretch it
      if (fs_q != WAIT) begin
        dly_q   <= act_q[`TF_ACT_DELAY]; // RULE7
        div_q   <= 19'h0;
        steps_q <= 3'h0;
      end else if (step_tk) begin
        div_q   <= 19'h0;
        steps_q <= steps_q + 3'h1; // RULE7
      end else begin
        div_q <= div_q + 19'h1;
      end
      out_en_q           <= (fs_d == RUN); // RULE2 RULE3
      alert_line_n_out_q <= 1'b0;
      alert_line_n_oe_q  <= stat_d[`TF_ST_OTF] | stat_d[`TF_ST_UTF]; // RULE1
    end
  end
endmodule

// file: verif/tf_host_model.sv
/*
  SMBus host model: a bit-level master that drives scl and pulls the data line.
  Assumes the bench resolves sda as ~(sda_oe | m_oe), with a pull-up.
*/
`timescale 1ns/100ps
module tf_host_model (
  // device side
  input  wire sda_oe,
  // bus drive
  output reg  scl,
  output reg  m_oe
);
  wire sda = ~(sda_oe | m_oe);
  // scl stands still high between frames
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  // start or repeated start; 800 ns scl period gives the device 4 clk a half,
  // and the first wait lets the device drop its ack before scl rises
  task st;
    begin
      #200 m_oe = 1'b0;
      #200 scl = 1'b1;
      #200 m_oe = 1'b1;
      #200 scl = 1'b0;
    end
  endtask
  // nine bits out and in; data changes only while scl is low
  task x(input [8:0] o, output [8:0] r);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        #200 m_oe = ~o[i];
        #200 scl = 1'b1;
        #200 r[i] = sda;
        #200 scl = 1'b0;
      end
    end
  endtask
  // stop: data rises while scl is high
  task sp;
    begin
      #200 m_oe = 1'b1;
      #200 scl = 1'b1;
      #200 m_oe = 1'b0;
      #200;
    end
  endtask
  // write of n data bytes, low byte first
  task wr(input [7:0] c, input [15:0] d, input integer n);
    reg [8:0] r;
    begin
      st;
      x(9'h101, r);
      x({c, 1'b1}, r);
      if (n > 0) x({d[7:0], 1'b1}, r);
      if (n > 1) x({d[15:8], 1'b1}, r);
      sp;
    end
  endtask
  // read of one byte or one word; host nacks the last byte
  task rd(input [7:0] c, input w, output [15:0] d);
    reg [8:0] r;
    begin
      st;
      x(9'h101, r);
      x({c, 1'b1}, r);
      st;
      x(9'h103, r);
      x({8'hFF, ~w}, r);
      d = {8'h00, r[8:1]};
      if (w) x(9'h1FF, r);
      if (w) d[15:8] = r[8:1];
      sp;
    end
  endtask
endmodule

// file: verif/tf_fault_resp_monitor.sv
/*
  Checker for the temperature fault response block, bound to its top.
  Assumes the over limit never rises above 0x0064 and under never below -42.
*/
`timescale 1ns/100ps
module tf_fault_resp_monitor (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // pins and controls
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire [15:0] temp_val,
  input wire        on_cmd,
  input wire        out_en_q,
  input wire        alert_line_n_out_q,
  input wire        alert_line_n_oe_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // loosest limits the bench ever sets, so these imply a real fault
  wire hot  = $signed(temp_val) > $signed(16'h0064);
  wire cold = $signed(temp_val) < $signed(16'hFFD6);

  alert_level_a: assert property (alert_line_n_out_q == 1'b0)
    else $error("alert drive level not low");
  sda_level_a: assert property (sda_out == 1'b0)
    else $error("data drive level not low");
  hot_alert_a: assert property (hot |=> alert_line_n_oe_q)
    else $error("over fault without alert");
  cold_alert_a: assert property (cold |=> alert_line_n_oe_q)
    else $error("under fault without alert");
  shut_flag_a: assert property ($fell(out_en_q) && on_cmd |-> alert_line_n_oe_q)
    else $error("output dropped without a flagged fault");
  start_req_a: assert property ($rose(out_en_q) |-> $past(on_cmd))
    else $error("output rose without request");
  cmd_off_a: assert property (!on_cmd |-> ##[1:2] !out_en_q)
    else $error("output stayed on after command off");
  retry_gap_a: assert property ($fell(out_en_q) && on_cmd |-> ##1 (!out_en_q)[*8])
    else $error("restart came too soon");
  sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while scl high");

  cover property ($fell(out_en_q) && on_cmd);
  cover property ($rose(out_en_q) && alert_line_n_oe_q);
  cover property ($rose(alert_line_n_oe_q) && out_en_q);
endmodule

bind tf_fault_resp tf_fault_resp_monitor mon (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .temp_val(temp_val), .on_cmd(on_cmd), .out_en_q(out_en_q),
  .alert_line_n_out_q(alert_line_n_out_q), .alert_line_n_oe_q(alert_line_n_oe_q)
);

// file: verif/tf_fault_resp_tb.sv
/*
  Self-checking bench: register access over SMBus, then fault responses.
  Assumes the host model drives the bus; retry step shortened to 20 clk.
*/
`timescale 1ns/100ps
module tf_fault_resp_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         on_cmd = 1'b0;
  reg  [15:0] temp_val = 16'h0019;
  reg  [15:0] d;
  reg         p;
  wire        scl, m_oe, sda_oe, sda_out, out_en, al_out, al_oe;
  wire        sda = ~(sda_oe | m_oe);
  integer     mismatches = 0, tests_run = 0, cyc = 0, i, n, g;

  always #50 clk = ~clk;
  // hang guard, several times the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t timeout", $time);
      end_of_test;
    end
  end

  tf_fault_resp #(.RETRY_STEP_CYC(19'h00014)) uut (.clk(clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .temp_val(temp_val),
    .on_cmd(on_cmd), .out_en_q(out_en), .alert_line_n_out_q(al_out),
    .alert_line_n_oe_q(al_oe));
  tf_host_model host (.sda_oe(sda_oe), .scl(scl), .m_oe(m_oe));

  task end_of_test;
    begin
      if (mismatches == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task ck(input [15:0] v, input [15:0] e);
    begin
      tests_run++;
      if (v !== e) begin
        mismatches++;
        $display("[FAIL] %0t got %h expected %h", $time, v, e);
      end
    end
  endtask
  // reset value, write, read back
  task rw(input [7:0] c, input integer k, input [15:0] rv, input [15:0] nv);
    begin
      host.rd(c, k == 2, d);
      ck(d, rv);
      host.wr(c, nv, k);
      host.rd(c, k == 2, d);
      ck(d, nv);
    end
  endtask
  // clear, set action, go hot at 110; count restarts and first off gap
  task run(input [7:0] a, input integer win);
    begin
      temp_val = 16'h0019;
      on_cmd = 1'b0;
      host.wr(8'h03, 16'h0000, 0);
      host.wr(8'h50, {8'h00, a}, 1);
      on_cmd = 1'b1;
      repeat (3) @(negedge clk);
      temp_val = 16'h006E;
      n = 0;
      g = 0;
      p = out_en;
      repeat (win) begin
        @(negedge clk);
        if (out_en && !p) n++;
        if (!out_en && n == 0) g++;
        p = out_en;
      end
    end
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    on_cmd = 1'b1;
    repeat (4) @(negedge clk);
    rw(8'h50, 1, 16'h0080, 16'h00A9);
    rw(8'h4F, 2, 16'h0064, 16'h0050);
    rw(8'h51, 2, 16'h005A, 16'h0046);
    rw(8'h52, 2, 16'hFFE2, 16'hFFEC);
    rw(8'h53, 2, 16'hFFD8, 16'hFFD6);
    host.rd(8'h60, 1'b1, d);
    ck(d, 16'hFFFF);
    // one retry, shortest then longest delay
    run(8'h88, 200);
    ck(n, 1);
    ck(g >= 20 && g <= 22, 1);
    ck(out_en, 0);
    run(8'h8F, 400);
    ck(g >= 160 && g <= 162, 1);
    // no retry: held off until cleared
    run(8'h80, 100);
    ck(n, 0);
    temp_val = 16'h0019;
    host.wr(8'h03, 16'h0000, 0);
    repeat (5) @(negedge clk);
    ck(out_en, 1);
    // endless retry stops only when commanded off
    run(8'hB8, 500);
    ck(n > 7, 1);
    on_cmd = 1'b0;
    repeat (3) @(negedge clk);
    ck(out_en, 0);
    // resume only below the warning limit
    run(8'hC0, 50);
    ck(out_en, 0);
    temp_val = 16'h004B;
    repeat (50) @(negedge clk);
    ck(out_en, 0);
    temp_val = 16'h003C;
    repeat (5) @(negedge clk);
    ck(out_en, 1);
    // reserved modes keep running but flag the fault
    for (i = 0; i < 2; i++) begin
      run({i[1:0], 6'h00}, 50);
      ck(out_en, 1);
      ck(al_oe, 1);
      host.rd(8'h7D, 1'b0, d);
      ck(d[7], 1);
    end
    temp_val = 16'h0019;
    host.wr(8'h03, 16'h0000, 0);
    repeat (3) @(negedge clk);
    ck(al_oe, 0);
    temp_val = 16'hFFCE;
    repeat (3) @(negedge clk);
    ck(al_oe, 1);
    // under fault and under warning flagged; clear only the fault bit
    host.rd(8'h7D, 1'b0, d);
    ck(d, 16'h0030);
    temp_val = 16'h0019;
    host.wr(8'h7D, 16'h0010, 1);
    host.rd(8'h7D, 1'b0, d);
    ck(d, 16'h0020);
    ck(al_oe, 0);
    end_of_test;
  end
endmodule
